// ### hdl/voice_tx_params.svh
/*
 * Register offsets, field positions and reset values of the
 * transmit voice FIFO block.
 * Assumes byte-wide registers on a 16-bit register address.
 */
`ifndef VOICE_TX_PARAMS_SVH
`define VOICE_TX_PARAMS_SVH

`define OFS_DATA      16'h2750
`define OFS_MUTE      16'h2751
`define OFS_CTL       16'h2752
`define OFS_RPTR      16'h2753
`define OFS_WPTR      16'h2754
`define OFS_SIZE      16'h2755
`define OFS_IRQ_STAT  16'h2756
`define OFS_IRQ_MASK  16'h2757
`define OFS_FAULT     16'h2758
`define OFS_STATUS    16'h275a

`define CTL_FILL      0
`define CTL_CLEAR     1
`define CTL_MUTE      2
`define CTL_GO        3

`define STS_POP       2
`define STS_PUSH      3
`define STS_FILL      4

`define FLT_UNDER     0
`define FLT_OVER      1

`define IRQ_DMA_DONE  0
`define IRQ_FILL_DONE 1
`define IRQ_OVER      2
`define IRQ_UNDER     3

`define RST_BYTE      8'h00
`define FIFO_DEPTH    128
`define FILL_LAST     7'h7f

`endif

// ### hdl/voice_tx_pkg.sv
/*
 * Types of the transmit voice FIFO block.
 * Assumes a 128-entry byte buffer with 7-bit addresses.
 */
package voice_tx_pkg;

	typedef enum logic [3:0] {
		DMA_IDLE  = 4'b0001,
		DMA_FETCH = 4'b0010,
		DMA_LOAD  = 4'b0100,
		DMA_SEND  = 4'b1000
	} dma_state_e;

	typedef struct packed {
		logic       en;
		logic [6:0] addr;
		logic [7:0] data;
	} mem_wr_s;

	typedef struct packed {
		logic       en;
		logic [6:0] addr;
	} mem_rd_s;

endpackage

// ### hdl/voice_tx_mem.sv
/*
 * Byte buffer of the transmit voice FIFO, one write and one read port.
 * Assumes one clock; read data are registered and valid one cycle later.
 */
`timescale 1ns/10ps
`default_nettype none

module voice_tx_mem #(
	parameter int DEPTH = 128
) (
	input  wire logic                 mclk_i,
	input  wire voice_tx_pkg::mem_wr_s wr_i,
	input  wire voice_tx_pkg::mem_rd_s rd_i,
	output logic [7:0]                rd_data_o
);

	logic [7:0] store_q [DEPTH];

	generate
		if (DEPTH != 128)
		begin : g_check
			$error("voice_tx_mem serves only a depth of 128");
		end
	endgenerate

	always_ff @(posedge mclk_i)
	begin
		if (wr_i.en)
		begin
			store_q[wr_i.addr] <= wr_i.data;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rd_i.en)
		begin
			rd_data_o <= store_q[rd_i.addr];
		end
	end

endmodule

`default_nettype wire

// ### hdl/voice_tx_fifo_dma.sv
/*
 * Transmit voice FIFO with DMA into the MAC transmit FIFO.
 * Assumes the register master, encoder and MAC side are synchronous
 * to mclk_i; the MAC side accepts a byte when mac_ready_i is high.
 */
// Local design decision: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "voice_tx_params.svh"

module voice_tx_fifo_dma #(
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic        enc_valid_i,
	input  wire logic [7:0]  enc_data_i,
	output logic             enc_ready_o,
	output logic             mac_valid_o,
	output logic      [7:0]  mac_data_o,
	input  wire logic        mac_ready_i,
	output logic             irq_o
);

	generate
		if (DEPTH != 128)
		begin : g_check
			$error("voice_tx_fifo_dma serves only a depth of 128");
		end
	endgenerate

	voice_tx_pkg::dma_state_e state_q;
	voice_tx_pkg::dma_state_e state_d;
	voice_tx_pkg::mem_wr_s    mem_wr;
	voice_tx_pkg::mem_rd_s    mem_rd;

	logic [7:0] mute_val_q;
	logic       mute_en_q;
	logic [7:0] size_q;
	logic [7:0] count_q;
	logic [7:0] rptr_q;
	logic [7:0] wptr_q;
	logic       fill_busy_q;
	logic [6:0] fill_idx_q;
	logic       push_seen_q;
	logic       pop_seen_q;
	logic       over_q;
	logic       under_q;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_mask_q;
	logic [7:0] rdata_q;
	logic       sel_fifo_q;
	logic [7:0] mac_data_q;
	logic [7:0] mem_q;

	wire hit_data   = addr_i == `OFS_DATA;
	wire hit_mute   = addr_i == `OFS_MUTE;
	wire hit_ctl    = addr_i == `OFS_CTL;
	wire hit_rptr   = addr_i == `OFS_RPTR;
	wire hit_wptr   = addr_i == `OFS_WPTR;
	wire hit_size   = addr_i == `OFS_SIZE;
	wire hit_istat  = addr_i == `OFS_IRQ_STAT;
	wire hit_imask  = addr_i == `OFS_IRQ_MASK;
	wire hit_fault  = addr_i == `OFS_FAULT;
	wire hit_status = addr_i == `OFS_STATUS;

	wire wr_ctl   = wr_i & hit_ctl;
	wire go_req   = wr_ctl & wdata_i[`CTL_GO];
	wire clr_req  = wr_ctl & wdata_i[`CTL_CLEAR];
	wire fill_req = wr_ctl & wdata_i[`CTL_FILL];
	// Data register write pushes a byte
	wire sw_push  = wr_i & hit_data;
	wire sw_pop   = rd_i & hit_data;

	// Wrap bit tells full from empty
	wire same_addr = rptr_q[6:0] == wptr_q[6:0];
	wire empty     = same_addr & (rptr_q[7] == wptr_q[7]);
	wire full      = same_addr & (rptr_q[7] != wptr_q[7]);

	assign enc_ready_o = ~fill_busy_q & ~sw_push;
	wire enc_push      = enc_valid_i & enc_ready_o;

	// Push on full and pop on empty
	wire push_req   = (sw_push | enc_push) & ~fill_busy_q;
	wire push_ok    = push_req & ~full;
	wire over_ev    = push_req & full;
	wire [7:0] push_byte = sw_push ? wdata_i : enc_data_i;

	wire dma_fetch  = (state_q == voice_tx_pkg::DMA_FETCH) & ~sw_pop;
	wire pop_req    = sw_pop | dma_fetch;
	wire pop_ok     = pop_req & ~empty;
	wire under_ev   = pop_req & empty;

	wire fill_start = fill_req & ~fill_busy_q;
	wire fill_done  = fill_busy_q & (fill_idx_q == `FILL_LAST);
	wire send_last  = (state_q == voice_tx_pkg::DMA_SEND) & mac_ready_i & (count_q == 8'h01);
	wire zero_done  = (state_q == voice_tx_pkg::DMA_IDLE) & go_req & (size_q == 8'h00);
	wire dma_done   = send_last | zero_done;

	// Fill writes mute value at every entry
	assign mem_wr.en   = fill_busy_q | push_ok;
	assign mem_wr.addr = fill_busy_q ? fill_idx_q : wptr_q[6:0];
	assign mem_wr.data = fill_busy_q ? mute_val_q : push_byte;

	assign mem_rd.en   = pop_req;
	assign mem_rd.addr = rptr_q[6:0];

	voice_tx_mem #(
		.DEPTH     (DEPTH)
	) u_mem (
		.mclk_i    (mclk_i),
		.wr_i      (mem_wr),
		.rd_i      (mem_rd),
		.rd_data_o (mem_q)
	);

	wire [7:0] pop_byte = mute_en_q ? mute_val_q : mem_q;

	wire [3:0] irq_events = {under_ev, over_ev, fill_done, dma_done};
	wire [3:0] irq_w1c    = (wr_i & hit_istat) ? wdata_i[3:0] : 4'h0;

	wire [7:0] ctl_rd    = {5'h00, mute_en_q, 2'h0};
	wire [7:0] status_rd = {3'h0, fill_busy_q, push_seen_q, pop_seen_q, 2'h0};
	wire [7:0] fault_rd  = {6'h00, over_q, under_q};

	wire [7:0] rd_mux =
		hit_mute   ? mute_val_q :
		hit_ctl    ? ctl_rd :
		hit_rptr   ? rptr_q :
		hit_wptr   ? wptr_q :
		hit_size   ? size_q :
		hit_istat  ? {4'h0, irq_stat_q} :
		hit_imask  ? {4'h0, irq_mask_q} :
		hit_fault  ? fault_rd :
		hit_status ? status_rd :
		8'h00;

	assign rdata_o     = sel_fifo_q ? pop_byte : rdata_q;
	assign mac_valid_o = state_q == voice_tx_pkg::DMA_SEND;
	assign mac_data_o  = mac_data_q;
	assign irq_o       = |(irq_stat_q & irq_mask_q);

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_q    <= `RST_BYTE;
			sel_fifo_q <= 1'b0;
		end
		else
		begin
			rdata_q    <= rd_i ? rd_mux : `RST_BYTE;
			sel_fifo_q <= sw_pop;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mute_val_q <= `RST_BYTE;
			mute_en_q  <= 1'b0;
			size_q     <= `RST_BYTE;
			irq_mask_q <= 4'h0;
		end
		else if (wr_i)
		begin
			if (hit_mute)
				mute_val_q <= wdata_i;
			if (hit_ctl)
				mute_en_q <= wdata_i[`CTL_MUTE];
			if (hit_size)
				size_q <= wdata_i;
			if (hit_imask)
				irq_mask_q <= wdata_i[3:0];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rptr_q <= `RST_BYTE;
		else if (clr_req)
			rptr_q <= `RST_BYTE;
		else if (wr_i & hit_rptr)
			rptr_q <= wdata_i;
		else if (pop_ok)
			rptr_q <= rptr_q + 8'h01;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			wptr_q <= `RST_BYTE;
		else if (clr_req)
			wptr_q <= `RST_BYTE;
		else if (wr_i & hit_wptr)
			wptr_q <= wdata_i;
		else if (push_ok)
			wptr_q <= wptr_q + 8'h01;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fill_busy_q <= 1'b0;
			fill_idx_q  <= 7'h00;
		end
		else if (fill_start)
		begin
			fill_busy_q <= 1'b1;
			fill_idx_q  <= 7'h00;
		end
		else if (fill_busy_q)
		begin
			fill_busy_q <= ~fill_done;
			fill_idx_q  <= fill_idx_q + 7'h01;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			push_seen_q <= 1'b0;
			pop_seen_q  <= 1'b0;
			over_q      <= 1'b0;
			under_q     <= 1'b0;
		end
		else
		begin
			push_seen_q <= push_ok;
			pop_seen_q  <= pop_ok;
			over_q      <= over_ev | (over_q & ~clr_req);
			under_q     <= under_ev | (under_q & ~clr_req);
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_stat_q <= 4'h0;
		else
			irq_stat_q <= irq_events | (irq_stat_q & ~irq_w1c);
	end

	// Go starts a transfer, no stored bit
	// Pop, load, send until count reached
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			voice_tx_pkg::DMA_IDLE:
			begin
				if (go_req && size_q != 8'h00)
					state_d = voice_tx_pkg::DMA_FETCH;
			end
			voice_tx_pkg::DMA_FETCH:
			begin
				if (dma_fetch)
					state_d = voice_tx_pkg::DMA_LOAD;
			end
			voice_tx_pkg::DMA_LOAD:
			begin
				state_d = voice_tx_pkg::DMA_SEND;
			end
			voice_tx_pkg::DMA_SEND:
			begin
				if (send_last)
					state_d = voice_tx_pkg::DMA_IDLE;
				else if (mac_ready_i)
					state_d = voice_tx_pkg::DMA_FETCH;
			end
			default:
			begin
				state_d = voice_tx_pkg::DMA_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_q <= voice_tx_pkg::DMA_IDLE;
		else
			state_q <= state_d;
	end

	// Count loaded from size on start
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count_q <= `RST_BYTE;
		else if (state_q == voice_tx_pkg::DMA_IDLE && go_req)
			count_q <= size_q;
		else if (state_q == voice_tx_pkg::DMA_SEND && mac_ready_i)
			count_q <= count_q - 8'h01;
	end

	// Popped byte, or the mute value when muted, sent to the MAC
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			mac_data_q <= `RST_BYTE;
		else if (state_q == voice_tx_pkg::DMA_LOAD)
			mac_data_q <= pop_byte;
	end

endmodule

`default_nettype wire

// ### verif/voice_tx_fifo_dma_props.sv
/*
 * Port-level checker of the transmit voice FIFO block.
 * Assumes the register master and MAC side are synchronous to mclk_i.
 */
`timescale 1ns/10ps
`default_nettype none
`include "voice_tx_params.svh"

module voice_tx_fifo_dma_props (
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [7:0]  rdata_o,
	input wire logic        enc_ready_o,
	input wire logic        mac_valid_o,
	input wire logic [7:0]  mac_data_o,
	input wire logic        mac_ready_i
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence mute_wr; wr_i && addr_i == `OFS_MUTE; endsequence
	sequence mute_rd; rd_i && addr_i == `OFS_MUTE; endsequence
	sequence fill_wr; wr_i && addr_i == `OFS_CTL && wdata_i[`CTL_FILL]; endsequence
	sequence sts_rd; rd_i && addr_i == `OFS_STATUS; endsequence

	mute_readback_a: assert property (mute_wr ##1 mute_rd |=> rdata_o == $past(wdata_i, 2))
		else $error("mute value read back wrong");
	fill_busy_a: assert property (fill_wr ##1 sts_rd |=> rdata_o[`STS_FILL])
		else $error("fill busy not shown");
	rd_quiet_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data without read");
	unmapped_zero_a: assert property (rd_i && addr_i == 16'h2759 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	ctl_bits_a: assert property (rd_i && addr_i == `OFS_CTL |=> rdata_o[7:3] == 0 && rdata_o[1:0] == 0)
		else $error("write-only control bits read back");
	sts_bits_a: assert property (sts_rd |=> rdata_o[7:5] == 0 && rdata_o[1:0] == 0)
		else $error("reserved status bits set");
	enc_block_a: assert property (wr_i && addr_i == `OFS_DATA |-> !enc_ready_o)
		else $error("encoder ready during data write");
	mac_hold_a: assert property (mac_valid_o && !mac_ready_i |=> mac_valid_o && $stable(mac_data_o))
		else $error("MAC byte dropped while stalled");
	mac_gap_a: assert property (mac_valid_o && mac_ready_i |=> !mac_valid_o [*2])
		else $error("MAC byte spacing too short");
endmodule

bind voice_tx_fifo_dma voice_tx_fifo_dma_props u_props (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .enc_ready_o(enc_ready_o), .mac_valid_o(mac_valid_o), .mac_data_o(mac_data_o),
	.mac_ready_i(mac_ready_i)
);
`default_nettype wire

// ### verif/mac_sink.sv
/*
 * MAC transmit FIFO model taking DMA bytes, prompt or stalling.
 * Assumes one clock shared with the block.
 */
`timescale 1ns/10ps
`default_nettype none

module mac_sink (
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic       mac_valid_i,
	input  wire logic [7:0] mac_data_i,
	input  wire logic       slow_i,
	output logic            mac_ready_o,
	output logic      [7:0] last_o,
	output logic      [7:0] count_o
);
	logic tog_q;
	assign mac_ready_o = !slow_i | tog_q;
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tog_q <= 0;
			last_o <= 8'h00;
			count_o <= 8'h00;
		end
		else
		begin
			tog_q <= !tog_q;
			if (mac_valid_i & mac_ready_o)
			begin
				last_o <= mac_data_i;
				count_o <= count_o + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### verif/voice_tx_fifo_dma_tb.sv
/*
 * Self-checking bench of the transmit voice FIFO block.
 * Assumes the MAC model in mac_sink; the bench plays encoder and CPU.
 */
`timescale 1ns/10ps
`default_nettype none
`include "voice_tx_params.svh"

module voice_tx_fifo_dma_tb;
	typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_s;
	logic        mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, enc_valid_i = 0, slow = 0;
	logic        chk_q = 0, chk_r = 0, enc_ready_o, mac_valid_o, mac_ready_i, irq_o;
	logic [15:0] addr_i = 0;
	logic [7:0]  wdata_i = 0, enc_data_i = 0, exp_q = 0, exp_r = 0, rdata_o, mac_data_o, last, cnt;
	int          num_errors = 0, compares = 0, cyc = 0;
	row_s        rows [7] = '{'{16'h2751, 8'ha5, 8'ha5}, '{16'h2753, 8'h12, 8'h12}, '{16'h2754, 8'h34, 8'h34},
		'{16'h2755, 8'h03, 8'h03}, '{16'h2757, 8'h0f, 8'h0f}, '{16'h2759, 8'hff, 8'h00}, '{16'h2752, 8'h04, 8'h04}};

	voice_tx_fifo_dma u_voice_tx_fifo_dma (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .enc_valid_i(enc_valid_i),
		.enc_data_i(enc_data_i), .enc_ready_o(enc_ready_o), .mac_valid_o(mac_valid_o),
		.mac_data_o(mac_data_o), .mac_ready_i(mac_ready_i), .irq_o(irq_o));
	mac_sink u_mac_sink (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .mac_valid_i(mac_valid_o), .mac_data_i(mac_data_o),
		.slow_i(slow), .mac_ready_o(mac_ready_i), .last_o(last), .count_o(cnt));

	initial forever #25 mclk_i = ~mclk_i;

	task tally_and_finish();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	// Read or write; for a read d is the expected byte
	task op(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= d;
		exp_q <= d;
		chk_q <= !w;
	endtask
	task idle(input int n);
		repeat (n)
		begin
			@(posedge mclk_i);
			wr_i <= 0;
			rd_i <= 0;
		end
	endtask

	always @(posedge mclk_i)
	begin
		chk_r <= rd_i & chk_q;
		exp_r <= exp_q;
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end
	always @(negedge mclk_i)
		if (chk_r)
			cmp("rdata_o", exp_r, rdata_o);

	initial
	begin
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1;
		for (int a = 16'h2751; a < 16'h275b; a++) op(0, a[15:0], 8'h00);
		foreach (rows[i])
		begin
			op(1, rows[i].a, rows[i].d);
			op(0, rows[i].a, rows[i].e);
		end
		op(1, `OFS_CTL, 8'h02);
		op(0, `OFS_RPTR, 8'h00);
		op(0, `OFS_WPTR, 8'h00);
		op(1, `OFS_DATA, 8'h11);
		op(0, `OFS_STATUS, 8'h08);
		op(1, `OFS_DATA, 8'h22);
		op(0, `OFS_WPTR, 8'h02);
		op(0, `OFS_DATA, 8'h11);
		op(0, `OFS_STATUS, 8'h04);
		op(1, `OFS_CTL, 8'h04);
		op(0, `OFS_DATA, 8'ha5);
		op(0, `OFS_RPTR, 8'h02);
		op(0, `OFS_DATA, 8'ha5);
		op(0, `OFS_FAULT, 8'h01);
		idle(1);
		#1 cmp("irq_o", 8'h01, {7'h00, irq_o});
		op(1, `OFS_IRQ_STAT, 8'h08);
		op(1, `OFS_CTL, 8'h02);
		op(0, `OFS_FAULT, 8'h00);
		idle(1);
		#1 cmp("irq_o", 8'h00, {7'h00, irq_o});
		for (int i = 0; i < 129; i++)
		begin
			@(posedge mclk_i);
			enc_valid_i <= 1;
			enc_data_i <= i[7:0];
		end
		@(posedge mclk_i);
		enc_valid_i <= 0;
		op(0, `OFS_WPTR, 8'h80);
		op(0, `OFS_FAULT, 8'h02);
		op(0, `OFS_DATA, 8'h00);
		slow <= 1;
		op(1, `OFS_CTL, 8'h08);
		op(0, `OFS_CTL, 8'h00);
		idle(1);
		repeat (40) @(posedge mclk_i);
		#1 cmp("mac count", 8'h03, cnt);
		cmp("mac last", 8'h03, last);
		op(0, `OFS_RPTR, 8'h04);
		op(0, `OFS_IRQ_STAT, 8'h05);
		op(1, `OFS_MUTE, 8'h5a);
		op(1, `OFS_CTL, 8'h01);
		op(0, `OFS_STATUS, 8'h10);
		#1 cmp("enc_ready_o", 8'h00, {7'h00, enc_ready_o});
		idle(1);
		repeat (130) @(posedge mclk_i);
		op(0, `OFS_STATUS, 8'h00);
		op(1, `OFS_CTL, 8'h02);
		op(0, `OFS_DATA, 8'h5a);
		// Muted DMA from an empty buffer still sends the mute value
		op(1, `OFS_MUTE, 8'h77);
		op(1, `OFS_CTL, 8'h0c);
		idle(1);
		repeat (30) @(posedge mclk_i);
		#1 cmp("mac count", 8'h06, cnt);
		cmp("mac last", 8'h77, last);
		// Zero size ends at once with no byte sent
		op(1, `OFS_SIZE, 8'h00);
		op(1, `OFS_IRQ_STAT, 8'h0f);
		op(1, `OFS_CTL, 8'h08);
		op(0, `OFS_IRQ_STAT, 8'h01);
		op(0, `OFS_FAULT, 8'h01);
		idle(3);
		#1 cmp("mac count", 8'h06, cnt);
		cmp("irq_o", 8'h01, {7'h00, irq_o});
		// Reset in mid-run
		@(posedge mclk_i);
		rst_n_i <= 0;
		idle(2);
		#1 cmp("irq_o", 8'h00, {7'h00, irq_o});
		cmp("mac_valid_o", 8'h00, {7'h00, mac_valid_o});
		@(posedge mclk_i);
		rst_n_i <= 1;
		op(0, `OFS_MUTE, 8'h00);
		op(0, `OFS_RPTR, 8'h00);
		op(0, `OFS_WPTR, 8'h00);
		op(0, `OFS_IRQ_STAT, 8'h00);
		op(0, `OFS_SIZE, 8'h00);
		idle(2);
		#1 cmp("mac count", 8'h00, cnt);
		tally_and_finish();
	end
endmodule
`default_nettype wire
